// ===== src/igss_pkg.sv
// Constants and types shared by the IMA group start-up and status block.
// Operation
// - Group up only when both group machines operational
// - Group down when either group machine not operational
// - While down, report highest-priority single cause
// - Traffic down entry signalled to user and ATM
// - ATM management gets both the down and the up notification
// - Traffic up return signalled to user and ATM
// - No cell lost when links added or recovered
// - No cell lost when links removed or inhibited
// - All accepted links go tx-Usable in one update
// - All accepted rx-Active together after tx reported
// - All accepted tx-Active together after rx reported
// - Wait one second before rx-Active, unless far usable
// - Wait one second before tx-Active, unless far active
// - Link insertion aligned to round-robin sequence wrap
// - Operational only when minimum tx/rx links possible
package igss_pkg;
   // Link count and cause count served by default
   localparam int IGSS_NLINK = 8;
   localparam int IGSS_NCAUSE = 8;
   localparam int IGSS_CAUSE_W = 4;
   // Group state machine codes as seen on the local and remote state inputs
   localparam int IGSS_GSM_W = 3;
   localparam logic [2:0] IGSS_GSM_OPERATIONAL = 3'h4;
   // Cause code reported while the group is up or with no cause pending
   localparam logic [3:0] IGSS_CAUSE_NONE = 4'h0;
   // Start-up wait, one second, in nanoseconds, and the clock period
   localparam longint IGSS_WAIT_NS = 1000000000;
   localparam longint IGSS_CLK_NS = 20;
   // Least wait rounds up to whole cycles
   localparam int IGSS_WAIT_CYC = int'((IGSS_WAIT_NS + IGSS_CLK_NS - 1) / IGSS_CLK_NS);
   // Start-up sequencer steps
   typedef enum logic [2:0] {
      IGSS_ST_IDLE,
      IGSS_ST_TXU,
      IGSS_ST_WRX,
      IGSS_ST_WTX,
      IGSS_ST_RUN
   } igss_state_t;
endpackage : igss_pkg

// ===== src/igss_prio.sv
// Fixed-priority encoder picking the most urgent pending cause.
`timescale 1ns/1ps
module igss_prio #(
   parameter int N = 8,
   parameter int W = 3
) (
   input wire logic [N-1:0] req,
   output logic [W-1:0] idx,
   output logic any
);
   // Bit 0 is the most urgent; scan from the top down so the lowest set bit, written last, wins
   always_comb begin
      idx = '0;
      any = 1'b0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            idx = W'(i);
            any = 1'b1;
         end
      end
   end

   if (N < 1 || (1 << W) < N) begin : g_chk
      $error("igss_prio: index width too small for cause count");
   end
endmodule : igss_prio

// ===== src/igss_rr.sv
// Round-robin cell distributor over the active transmit links.
`timescale 1ns/1ps
module igss_rr #(
   parameter int N = 8,
   parameter int W = 3
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [N-1:0] new_mask,
   input wire logic cell_valid,
   output logic cell_ready,
   output logic [W-1:0] cell_link,
   output logic [N-1:0] cur_mask
);
   logic [N-1:0] next_mask;
   logic [W-1:0] next_link;
   logic found;
   logic [W-1:0] nxt;

   // Lowest set bit of m strictly above lo
   function automatic logic [W:0] above(input logic [N-1:0] m, input int lo);
      logic [W:0] r;
      r = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (m[i] && i > lo) begin
            r = {1'b1, W'(i)};
         end
      end
      return r;
   endfunction : above

   // Cells are taken only while some link is in the round, so none is dropped
   assign cell_ready = |cur_mask;

   // Mask changes only at the wrap of the round or while the round is empty, never mid-sequence
   always_comb begin
      next_mask = cur_mask;
      next_link = cell_link;
      {found, nxt} = above(cur_mask, int'(cell_link));
      if (cur_mask == '0 || (cell_valid && !found)) begin
         next_mask = new_mask;
         {found, nxt} = above(new_mask, -1);
         next_link = nxt;
      end else if (cell_valid) begin
         next_link = nxt;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cur_mask <= '0;
         cell_link <= '0;
      end else begin
         cur_mask <= next_mask;
         cell_link <= next_link;
      end
   end

   if (N < 1 || (1 << W) < N) begin : g_chk
      $error("igss_rr: link index width too small");
   end
endmodule : igss_rr

// ===== src/igss_top.sv
// Group status, start-up sequencing and cell distribution for one IMA group.
`timescale 1ns/1ps
module igss_top #(
   parameter int NLINK = igss_pkg::IGSS_NLINK,
   parameter int NCAUSE = igss_pkg::IGSS_NCAUSE,
   parameter int WAIT_CYCLES = igss_pkg::IGSS_WAIT_CYC,
   localparam int LW = $clog2(NLINK),
   localparam int CNT_W = $clog2(NLINK + 1)
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [igss_pkg::IGSS_GSM_W-1:0] local_gsm,
   input wire logic [igss_pkg::IGSS_GSM_W-1:0] remote_gsm,
   input wire logic [NCAUSE-1:0] cause_req,
   output logic group_up,
   output logic [igss_pkg::IGSS_CAUSE_W-1:0] fail_cause,
   output logic um_down_evt,
   output logic atm_down_evt,
   output logic um_up_evt,
   output logic atm_up_evt,
   input wire logic startup_go,
   input wire logic startup_abort,
   input wire logic icp_update,
   input wire logic [NLINK-1:0] cfg_links,
   input wire logic [NLINK-1:0] accepted_links,
   input wire logic [NLINK-1:0] fe_tx_usable,
   input wire logic [NLINK-1:0] fe_rx_active,
   input wire logic [CNT_W-1:0] min_tx_links,
   input wire logic [CNT_W-1:0] min_rx_links,
   output logic [NLINK-1:0] tx_usable_mask,
   output logic [NLINK-1:0] rx_active_mask,
   output logic [NLINK-1:0] tx_active_mask,
   output logic startup_busy,
   output logic gsm_op_allow,
   input wire logic [NLINK-1:0] link_enable,
   input wire logic cell_valid,
   output logic cell_ready,
   output logic [LW-1:0] cell_link
);
   import igss_pkg::*;

   localparam int TW = $clog2(WAIT_CYCLES + 1);
   localparam int PW = (NCAUSE > 1) ? $clog2(NCAUSE) : 1;

   logic both_op;
   logic next_up;
   logic [IGSS_CAUSE_W-1:0] next_cause;
   logic [PW-1:0] prio_idx;
   logic prio_any;
   igss_state_t state;
   igss_state_t next_state;
   logic [TW-1:0] timer;
   logic [TW-1:0] next_timer;
   logic [NLINK-1:0] next_txu;
   logic [NLINK-1:0] next_rxa;
   logic [NLINK-1:0] next_txa;
   logic [NLINK-1:0] acc;
   logic [NLINK-1:0] next_acc;
   logic next_allow;
   logic timer_done;
   logic fe_all_usable;
   logic fe_all_active;
   logic cnt_ok;
   logic [NLINK-1:0] rr_mask;

   // Number of links in a mask
   function automatic logic [CNT_W-1:0] popcnt(input logic [NLINK-1:0] m);
      logic [CNT_W-1:0] c;
      c = '0;
      for (int i = 0; i < NLINK; i++) begin
         c = c + CNT_W'(m[i]);
      end
      return c;
   endfunction : popcnt

   // Group status: up only when both ends are operational
   assign both_op = (local_gsm == IGSS_GSM_OPERATIONAL) && (remote_gsm == IGSS_GSM_OPERATIONAL);

   igss_prio #(.N(NCAUSE), .W(PW)) u_prio (
      .req(cause_req),
      .idx(prio_idx),
      .any(prio_any)
   );

   // Status and notification next values
   always_comb begin
      next_up = both_op;
      next_cause = IGSS_CAUSE_NONE;
      if (!both_op && prio_any) begin
         next_cause = IGSS_CAUSE_W'(prio_idx) + IGSS_CAUSE_W'(1);
      end
   end

   // Events are edges of the registered status, so a flap yields one pulse each way
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         group_up <= 1'b0;
         fail_cause <= IGSS_CAUSE_NONE;
         um_down_evt <= 1'b0;
         atm_down_evt <= 1'b0;
         um_up_evt <= 1'b0;
         atm_up_evt <= 1'b0;
      end else begin
         group_up <= next_up;
         fail_cause <= next_cause;
         um_down_evt <= group_up && !next_up;
         atm_down_evt <= group_up && !next_up;
         um_up_evt <= !group_up && next_up;
         atm_up_evt <= !group_up && next_up;
      end
   end

   // Start-up conditions: enough links, far-end early-exit terms, one-second wait
   assign cnt_ok = (min_tx_links != '0) && (min_rx_links != '0)
      && (popcnt(accepted_links) >= min_tx_links) && (popcnt(accepted_links) >= min_rx_links);
   assign fe_all_usable = (cfg_links & ~fe_tx_usable) == '0;
   assign fe_all_active = (cfg_links & ~fe_rx_active) == '0;
   assign timer_done = timer >= TW'(WAIT_CYCLES - 1);

   // Start-up sequencer; every mask change except the abort clear waits for an update boundary
   always_comb begin
      next_state = state;
      next_timer = (timer_done) ? timer : timer + TW'(1);
      next_txu = tx_usable_mask;
      next_rxa = rx_active_mask;
      next_txa = tx_active_mask;
      next_acc = acc;
      next_allow = gsm_op_allow;
      if (startup_abort) begin
         next_state = IGSS_ST_IDLE;
         next_txu = '0;
         next_rxa = '0;
         next_txa = '0;
         next_allow = 1'b0;
      end else begin
         unique case (state)
            IGSS_ST_IDLE: begin
               if (startup_go && cnt_ok) begin
                  next_acc = accepted_links; // Frozen so all steps name the same links
                  next_state = IGSS_ST_TXU;
               end
            end
            IGSS_ST_TXU: begin
               if (icp_update) begin
                  next_txu = acc;
                  next_timer = '0;
                  next_state = IGSS_ST_WRX;
               end
            end
            IGSS_ST_WRX: begin
               if (icp_update && (timer_done || fe_all_usable)) begin
                  next_rxa = acc;
                  next_timer = '0;
                  next_state = IGSS_ST_WTX;
               end
            end
            IGSS_ST_WTX: begin
               if (icp_update && (timer_done || fe_all_active)) begin
                  next_txa = acc;
                  next_allow = 1'b1;
                  next_state = IGSS_ST_RUN;
               end
            end
            IGSS_ST_RUN: begin
               next_state = IGSS_ST_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state <= IGSS_ST_IDLE;
         timer <= '0;
         tx_usable_mask <= '0;
         rx_active_mask <= '0;
         tx_active_mask <= '0;
         acc <= '0;
         gsm_op_allow <= 1'b0;
      end else begin
         state <= next_state;
         timer <= next_timer;
         tx_usable_mask <= next_txu;
         rx_active_mask <= next_rxa;
         tx_active_mask <= next_txa;
         acc <= next_acc;
         gsm_op_allow <= next_allow;
      end
   end

   assign startup_busy = (state != IGSS_ST_IDLE) && (state != IGSS_ST_RUN);

   // Distributor sees added, recovered, removed and inhibited links only at round wrap or while its round is empty
   igss_rr #(.N(NLINK), .W(LW)) u_rr (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .new_mask(tx_active_mask & link_enable),
      .cell_valid(cell_valid),
      .cell_ready(cell_ready),
      .cell_link(cell_link),
      .cur_mask(rr_mask)
   );

   // A wait shorter than two cycles cannot show the counter restarting, so it is refused
   if (NLINK < 2 || NCAUSE < 1 || WAIT_CYCLES < 2 || (1 << IGSS_CAUSE_W) <= NCAUSE) begin : g_chk
      $error("igss_top: unsupported link count, cause count or wait length");
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   sequence s_update_seen;
      $past(icp_update);
   endsequence

   sequence s_tx_reported;
      $past(tx_usable_mask == acc) && $past(acc != '0);
   endsequence

   sequence s_rx_reported;
      $past(rx_active_mask == acc) && $past(acc != '0);
   endsequence

   AST_UP_BOTH: assert property (both_op |=> group_up)
      else $error("group not up with both machines operational");
   AST_DOWN_EITHER: assert property (!both_op |=> !group_up && !um_up_evt)
      else $error("group up while a machine is not operational");
   AST_CAUSE: assert property ((!both_op && prio_any) |=>
      fail_cause == IGSS_CAUSE_W'($past(prio_idx)) + IGSS_CAUSE_W'(1))
      else $error("wrong failure cause reported");
   AST_DOWN_EVT: assert property ($fell(group_up) |-> um_down_evt && atm_down_evt ##1 !atm_down_evt)
      else $error("down entry not signalled as one pulse");
   AST_ATM_ONLY: assert property (atm_down_evt |-> $fell(group_up) && um_down_evt)
      else $error("stray notification to ATM management");
   AST_UP_EVT: assert property ($rose(group_up) |-> um_up_evt && atm_up_evt)
      else $error("up return not signalled");
   AST_NO_LOSS: assert property (cell_valid && cell_ready |-> rr_mask[cell_link])
      else $error("cell taken for a link outside the round");
   AST_TXU_ONE: assert property ($changed(tx_usable_mask) && tx_usable_mask != '0 |->
      s_update_seen and (tx_usable_mask == acc))
      else $error("tx usable not set for all links in one update");
   AST_RXA: assert property ($rose(|rx_active_mask) |-> s_update_seen and s_tx_reported)
      else $error("rx active before tx usable was reported");
   AST_TXA: assert property ($rose(|tx_active_mask) |-> s_update_seen and s_rx_reported)
      else $error("tx active before rx active was reported");
   AST_RX_WAIT: assert property ($rose(|rx_active_mask) |-> $past(timer_done || fe_all_usable))
      else $error("rx active reported before the wait");
   AST_TX_WAIT: assert property ($rose(|tx_active_mask) |-> $past(timer_done || fe_all_active))
      else $error("tx active reported before the wait");
   AST_MIN_LINKS: assert property ($rose(gsm_op_allow)
      |-> $past(popcnt(acc) >= min_tx_links && popcnt(acc) >= min_rx_links))
      else $error("operational allowed without enough links");
   AST_TIMER_RESTART: assert property (state == IGSS_ST_TXU && icp_update && !startup_abort
      |=> timer == '0 ##1 (timer == TW'(1) || state != IGSS_ST_WRX))
      else $error("wait counter did not restart at step entry");
   AST_TIMER_COUNT: assert property (state == IGSS_ST_WRX && !timer_done && !icp_update
      |=> timer == $past(timer) + TW'(1))
      else $error("wait counter skipped a cycle");

   // Status checks: a cause only while down, and each event except um_up_evt is a single pulse
   AST_CAUSE_NONE: assert property (both_op |=> fail_cause == IGSS_CAUSE_NONE)
      else $error("cause reported while both machines operational");
   AST_DOWN_ONCE: assert property (um_down_evt |=> !um_down_evt && !atm_down_evt)
      else $error("down event longer than one cycle");
   AST_UP_ONCE: assert property (atm_up_evt |-> $rose(group_up) && um_up_evt ##1 !atm_up_evt)
      else $error("up event not a single pulse");

   // Start-up step exits; the early-exit and the full-wait paths both end here
   sequence s_wrx_exit;
      state == IGSS_ST_WRX && icp_update && !startup_abort && (timer_done || fe_all_usable);
   endsequence

   sequence s_wtx_exit;
      state == IGSS_ST_WTX && icp_update && !startup_abort && (timer_done || fe_all_active);
   endsequence

   AST_RXA_TOGETHER: assert property (s_wrx_exit |=> rx_active_mask == acc && tx_active_mask == '0)
      else $error("rx active not set for all accepted links at once");
   AST_TXA_TOGETHER: assert property (s_wtx_exit
      |=> tx_active_mask == acc && gsm_op_allow && !startup_busy)
      else $error("tx active not set for all accepted links at once");
   AST_RX_EARLY: assert property (state == IGSS_ST_WRX && !(timer_done || fe_all_usable)
      |=> rx_active_mask == '0)
      else $error("rx active reported before the wait ran out");
   AST_TX_EARLY: assert property (state == IGSS_ST_WTX && !(timer_done || fe_all_active)
      |=> tx_active_mask == '0)
      else $error("tx active reported before the wait ran out");

   // A mask moving without an update pulse would split one step over two control cells
   AST_STEP_AT_UPDATE: assert property (!icp_update && !startup_abort
      |=> $stable(tx_usable_mask) && $stable(rx_active_mask) && $stable(tx_active_mask))
      else $error("link state mask changed between updates");

   // Abort withdraws every report and the permission to go operational
   AST_ABORT_CLEAR: assert property (startup_abort |=> tx_usable_mask == '0 && rx_active_mask == '0
      && tx_active_mask == '0 && !gsm_op_allow && !startup_busy)
      else $error("abort left link reports or permission standing");

   // A wrap is a cell taken at the highest link of the round; only then, or while the round is empty, may the round change
   logic rr_wrap;
   assign rr_wrap = cell_valid && cell_ready && ((rr_mask >> cell_link) == NLINK'(1));

   AST_ROUND_WRAP: assert property ($changed(rr_mask) |-> $past(rr_mask == '0 || rr_wrap))
      else $error("round mask changed in mid-sequence");
   AST_LINK_ADVANCE: assert property (cell_valid && cell_ready && !rr_wrap
      |=> cell_link > $past(cell_link) && rr_mask[cell_link])
      else $error("cell link did not advance within the round");
endmodule : igss_top

// ===== verif/igss_fe_model.sv
// Far-end group model: control-cell cadence, far-end link reports, remote state.
`timescale 1ns/1ps
module igss_fe_model #(
   parameter int NLINK = 8,
   parameter int ICP_GAP = 5
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic fe_prompt,
   input wire logic fe_op,
   input wire logic [NLINK-1:0] tx_usable_mask,
   input wire logic [NLINK-1:0] rx_active_mask,
   output logic icp_update,
   output logic [NLINK-1:0] fe_tx_usable,
   output logic [NLINK-1:0] fe_rx_active,
   output logic [2:0] remote_gsm
);
   import igss_pkg::*;
   int cnt;
   // Remote machine state follows the bench's choice; 3'h1 stands for any other state
   assign remote_gsm = fe_op ? IGSS_GSM_OPERATIONAL : 3'h1;
   // One update pulse per control-cell period; a slow far end reports nothing,
   // so the near end has to run its one-second wait out
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 0;
         icp_update <= 1'b0;
         fe_tx_usable <= '0;
         fe_rx_active <= '0;
      end else begin
         cnt <= (cnt == ICP_GAP - 1) ? 0 : cnt + 1;
         icp_update <= (cnt == ICP_GAP - 1);
         fe_tx_usable <= fe_prompt ? tx_usable_mask : '0;
         fe_rx_active <= fe_prompt ? rx_active_mask : '0;
      end
   end
endmodule : igss_fe_model

// ===== verif/igss_top_bench.sv
// Self-checking bench for group status, start-up sequencing and cell distribution.
`timescale 1ns/1ps
module igss_top_bench;
   import igss_pkg::*;
   localparam int WAIT = 20;
   localparam int GAP = 5;
   localparam logic [7:0] ACC = 8'h0f;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [2:0] local_gsm = 3'h0;
   logic [2:0] remote_gsm;
   logic [7:0] cause_req = 8'h00;
   logic startup_go = 1'b0;
   logic startup_abort = 1'b0;
   logic fe_prompt = 1'b0;
   logic fe_op = 1'b0;
   logic cell_valid = 1'b0;
   logic icp_update, group_up, um_down_evt, atm_down_evt, um_up_evt, atm_up_evt;
   logic startup_busy, gsm_op_allow, cell_ready;
   logic [7:0] cfg_links = ACC;
   logic [7:0] accepted_links = ACC;
   logic [7:0] link_enable = 8'h0f;
   logic [7:0] fe_tx_usable, fe_rx_active, tx_usable_mask, rx_active_mask, tx_active_mask;
   logic [3:0] min_tx_links = 4'h2;
   logic [3:0] min_rx_links = 4'h2;
   logic [3:0] fail_cause;
   logic [2:0] cell_link;
   logic last_gu = 1'b0;
   logic last_i = 1'b0;
   logic [23:0] last_m = 24'h000000;
   int error_cnt = 0;
   int check_count = 0;

   igss_top #(.NLINK(8), .NCAUSE(8), .WAIT_CYCLES(WAIT)) igss_top_inst (
      .clk_sys(clk_sys), .arst_n(arst_n), .local_gsm(local_gsm), .remote_gsm(remote_gsm),
      .cause_req(cause_req), .group_up(group_up), .fail_cause(fail_cause), .um_down_evt(um_down_evt),
      .atm_down_evt(atm_down_evt), .um_up_evt(um_up_evt), .atm_up_evt(atm_up_evt),
      .startup_go(startup_go), .startup_abort(startup_abort), .icp_update(icp_update),
      .cfg_links(cfg_links), .accepted_links(accepted_links), .fe_tx_usable(fe_tx_usable),
      .fe_rx_active(fe_rx_active), .min_tx_links(min_tx_links), .min_rx_links(min_rx_links),
      .tx_usable_mask(tx_usable_mask), .rx_active_mask(rx_active_mask), .tx_active_mask(tx_active_mask),
      .startup_busy(startup_busy), .gsm_op_allow(gsm_op_allow), .link_enable(link_enable),
      .cell_valid(cell_valid), .cell_ready(cell_ready), .cell_link(cell_link));

   igss_fe_model #(.NLINK(8), .ICP_GAP(GAP)) igss_fe_model_inst (
      .clk_sys(clk_sys), .arst_n(arst_n), .fe_prompt(fe_prompt), .fe_op(fe_op),
      .tx_usable_mask(tx_usable_mask), .rx_active_mask(rx_active_mask), .icp_update(icp_update),
      .fe_tx_usable(fe_tx_usable), .fe_rx_active(fe_rx_active), .remote_gsm(remote_gsm));

   // 50 MHz system clock
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task complete_run;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run

   // Every cycle: events follow group_up edges, masks that change to a nonzero tx_usable_mask move only after an update pulse.
   // Values read at the edge are the ones the previous edge produced.
   always @(posedge clk_sys) begin
      if (arst_n) begin
         check(um_down_evt, last_gu & ~group_up);
         check(atm_down_evt, last_gu & ~group_up);
         check({um_up_evt, atm_up_evt}, {2{~last_gu & group_up}});
         if ({tx_usable_mask, rx_active_mask, tx_active_mask} != last_m && tx_usable_mask != 8'h00)
            check(last_i, 1'b1);
      end
      last_gu = group_up;
      last_i = icp_update;
      last_m = {tx_usable_mask, rx_active_mask, tx_active_mask};
   end

   function automatic logic [7:0] mask_of(input int s);
      return (s == 0) ? tx_usable_mask : (s == 1) ? rx_active_mask : tx_active_mask;
   endfunction : mask_of

   // Count settled cycles until the chosen mask turns nonzero
   task automatic wait_mask(input int s, output int n);
      n = 0;
      while (mask_of(s) == 8'h00 && n < 400) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
   endtask : wait_mask

   task automatic status;
      @(posedge clk_sys);
      local_gsm <= IGSS_GSM_OPERATIONAL;
      fe_op <= 1'b1;
      @(posedge clk_sys);
      #1 check({group_up, fail_cause}, 5'h10);
      @(posedge clk_sys);
      fe_op <= 1'b0;
      @(posedge clk_sys);
      #1 check(group_up, 1'b0);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys);
         cause_req <= 8'hff << i;
         @(posedge clk_sys);
         #1 check(fail_cause, i + 1);
      end
      @(posedge clk_sys);
      fe_op <= 1'b1;
      local_gsm <= 3'h2;
      @(posedge clk_sys);
      #1 check(group_up, 1'b0);
      @(posedge clk_sys);
      local_gsm <= IGSS_GSM_OPERATIONAL;
      @(posedge clk_sys);
      #1 check({group_up, fail_cause}, 5'h10);
   endtask : status

   // Full start-up; a prompt far end ends both waits early, a silent one does not
   task automatic startup(input logic prompt);
      int n;
      @(posedge clk_sys);
      fe_prompt <= prompt;
      startup_go <= 1'b1;
      @(posedge clk_sys);
      startup_go <= 1'b0;
      #1 check(startup_busy, 1'b1);
      wait_mask(0, n);
      check({tx_usable_mask, rx_active_mask}, {ACC, 8'h00});
      wait_mask(1, n);
      check({rx_active_mask, tx_active_mask}, {ACC, 8'h00});
      check(prompt ? n < WAIT - 1 : n >= WAIT && n <= WAIT - 1 + GAP, 1'b1);
      wait_mask(2, n);
      check(tx_active_mask, ACC);
      check(prompt ? n < WAIT - 1 : n >= WAIT && n <= WAIT - 1 + GAP, 1'b1);
      check({gsm_op_allow, startup_busy}, 2'h2);
   endtask : startup

   task automatic abort_run;
      @(posedge clk_sys);
      startup_abort <= 1'b1;
      @(posedge clk_sys);
      startup_abort <= 1'b0;
      #1 check({tx_usable_mask, rx_active_mask, tx_active_mask, startup_busy}, 25'h0);
   endtask : abort_run

   // Too few accepted links for the minimum: start-up is never taken
   task automatic refused;
      @(posedge clk_sys);
      min_tx_links <= 4'h5;
      startup_go <= 1'b1;
      @(posedge clk_sys);
      startup_go <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1 check({startup_busy, gsm_op_allow}, 2'h0);
      check(cell_ready, 1'b0);
      // Same again with the receive minimum out of reach
      @(posedge clk_sys);
      min_tx_links <= 4'h2;
      min_rx_links <= 4'h5;
      startup_go <= 1'b1;
      @(posedge clk_sys);
      startup_go <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1 check({startup_busy, gsm_op_allow}, 2'h0);
      @(posedge clk_sys);
      min_rx_links <= 4'h2;
   endtask : refused

   // Back-to-back cells; expected links packed one hex digit each, first cell lowest
   task automatic cells(input logic [31:0] seq, input int n);
      int i;
      int w;
      i = 0;
      w = 0;
      @(posedge clk_sys);
      cell_valid <= 1'b1;
      while (i < n && w < 100) begin
         #1;
         if (cell_ready === 1'b1) begin
            check(cell_link, seq[4*i +: 3]);
            i++;
         end
         w++;
         @(posedge clk_sys);
      end
      cell_valid <= 1'b0;
      check(i, n);
   endtask : cells

   initial begin
      repeat (5) @(posedge clk_sys);
      arst_n <= 1'b1;
      status();
      refused();
      startup(1'b1);
      cells(32'h10, 2);
      link_enable <= 8'h05;
      cells(32'h02032, 5);
      link_enable <= 8'h0f;
      cells(32'h32102, 5);
      abort_run();
      startup(1'b0);
      abort_run();
      complete_run();
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (5000) @(posedge clk_sys);
      error_cnt++;
      complete_run();
   end
endmodule : igss_top_bench
